// file: pkg/spk_drv_pkg.sv
// Package with register map, field layout and timing for the speaker driver control registers.
package spk_drv_pkg;

  // ==========================================================================
  // Register indices and byte addresses
  // ==========================================================================
  // Printed offsets 2A and 2B are not multiples of four, so all three offsets are indices.
  localparam logic [7:0] left_speaker_driver_ctrl_idx = 8'h2a;
  localparam logic [7:0] right_speaker_driver_ctrl_idx = 8'h2b;
  localparam logic [7:0] headphone_driver_ctrl_idx = 8'h2c;
  localparam int addr_width = 12;
  localparam logic [11:0] left_ctrl_addr = {2'h0, left_speaker_driver_ctrl_idx, 2'h0};
  localparam logic [11:0] right_ctrl_addr = {2'h0, right_speaker_driver_ctrl_idx, 2'h0};

  // ==========================================================================
  // Field layout
  // ==========================================================================
  localparam int reserved_hi_msb = 7;
  localparam int reserved_hi_lsb = 5;
  localparam int gain_msb = 4;
  localparam int gain_lsb = 3;
  localparam int unmute_bit = 2;
  localparam int reserved_lo_bit = 1;
  localparam int applied_bit = 0;
  localparam int reg_width = 8;
  localparam logic [1:0] gain_reset = 2'h0;
  localparam logic unmute_reset = 1'b0;

  // Output stage gain codes.
  typedef enum logic [1:0] {
    gain_6db = 2'h0,
    gain_12db = 2'h1,
    gain_18db = 2'h2,
    gain_24db = 2'h3
  } spk_gain_t;

  // ==========================================================================
  // Apply timing
  // ==========================================================================
  localparam int clk_freq_hz = 50000000;
  localparam int apply_time_ns = 100;
  localparam int apply_cycles = (apply_time_ns * (clk_freq_hz / 1000000) + 999) / 1000;
  localparam int apply_cnt_width = 4;
  localparam logic [3:0] apply_cnt_last = 4'(apply_cycles - 1);

  // Per-channel apply sequencer.
  typedef enum logic [1:0] {
    st_applied = 2'b00,
    st_settling = 2'b01
  } apply_state_t;

endpackage

// file: core/speaker_driver_ctrl_regs.sv
// APB register bank for the left and right speaker driver controls.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/10ps

// What this block does
// [R1] Software writes zeros to bits 7..5; they reset to zero.
// [R2] Left gain bits 4..3 select 6, 12, 18 or 24 dB; reset 00.
// [R3] Right gain bits 4..3 use the same encoding independently; reset 00.
// [R4] Left bit 2: 0 mutes, 1 unmutes; reset muted.
// [R5] Right bit 2: 0 mutes, 1 unmutes; reset muted.
// [R6] Software writes zero to bit 1; it resets to zero.
// [R7] Left bit 0 read-only, 1 once programmed gains applied; reset 0.
// [R8] Right bit 0 read-only, 1 once programmed gains applied; reset 0.
// [R9] Status clears on gain or mute write, sets after settling, ignores writes.
module speaker_driver_ctrl_regs
  import spk_drv_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Driver controls
  output logic [1:0] left_speaker_driver_gain,
  output logic left_speaker_driver_unmute,
  output logic [1:0] right_speaker_driver_gain,
  output logic right_speaker_driver_unmute
);

  // ==========================================================================
  // Bus decode
  // ==========================================================================
  logic access;
  logic hit_left;
  logic hit_right;
  logic wr_left;
  logic wr_right;

  // A write lands in the access cycle, the one cycle in which pready is high.
  assign access = psel & penable;
  assign hit_left = (paddr == left_ctrl_addr);
  assign hit_right = (paddr == right_ctrl_addr);
  assign wr_left = access & pwrite & hit_left;
  assign wr_right = access & pwrite & hit_right;

  // ==========================================================================
  // Control fields
  // ==========================================================================
  // Reserved bits are not stored, so they always read zero.
  logic [1:0] lgain_reg, lgain_next;
  logic lmute_reg, lmute_next;
  logic [1:0] rgain_reg, rgain_next;
  logic rmute_reg, rmute_next;

  always_comb begin
    lgain_next = lgain_reg;
    lmute_next = lmute_reg;
    rgain_next = rgain_reg;
    rmute_next = rmute_reg;
    if (wr_left) begin
      lgain_next = pwdata[gain_msb:gain_lsb]; // [R2]
      lmute_next = pwdata[unmute_bit]; // [R4]
    end
    if (wr_right) begin
      rgain_next = pwdata[gain_msb:gain_lsb]; // [R3]
      rmute_next = pwdata[unmute_bit]; // [R5]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lgain_reg <= gain_reset; // [R2]
      lmute_reg <= unmute_reset; // [R4]
      rgain_reg <= gain_reset; // [R3]
      rmute_reg <= unmute_reset; // [R5]
    end else begin
      lgain_reg <= lgain_next;
      lmute_reg <= lmute_next;
      rgain_reg <= rgain_next;
      rmute_reg <= rmute_next;
    end
  end

  // ==========================================================================
  // Apply status sequencers
  // ==========================================================================
  // A fixed settle count stands in for the analog ramp; a rewrite restarts it.
  // A write in the cycle that the count expires wins over the set, since its new
  // setting is still pending and the status must not claim otherwise.
  apply_state_t lst_reg, lst_next, rst_reg, rst_next;
  logic [3:0] lcnt_reg, lcnt_next, rcnt_reg, rcnt_next;
  logic lapplied_reg, lapplied_next, rapplied_reg, rapplied_next;

  always_comb begin
    lst_next = lst_reg;
    lcnt_next = lcnt_reg;
    lapplied_next = lapplied_reg;
    if (wr_left) begin
      lst_next = st_settling; // [R9]
      lcnt_next = '0;
      lapplied_next = 1'b0; // [R7]
    end else begin
      case (lst_reg)
        st_settling: begin
          if (lcnt_reg == apply_cnt_last) begin
            lst_next = st_applied;
            lapplied_next = 1'b1; // [R7]
          end else begin
            lcnt_next = lcnt_reg + 4'h1;
          end
        end
        st_applied: begin
          lst_next = st_applied;
        end
        default: begin
          lst_next = st_applied;
        end
      endcase
    end
  end

  always_comb begin
    rst_next = rst_reg;
    rcnt_next = rcnt_reg;
    rapplied_next = rapplied_reg;
    if (wr_right) begin
      rst_next = st_settling; // [R9]
      rcnt_next = '0;
      rapplied_next = 1'b0; // [R8]
    end else begin
      case (rst_reg)
        st_settling: begin
          if (rcnt_reg == apply_cnt_last) begin
            rst_next = st_applied;
            rapplied_next = 1'b1; // [R8]
          end else begin
            rcnt_next = rcnt_reg + 4'h1;
          end
        end
        st_applied: begin
          rst_next = st_applied;
        end
        default: begin
          rst_next = st_applied;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lst_reg <= st_applied;
      lcnt_reg <= '0;
      lapplied_reg <= 1'b0; // [R7]
      rst_reg <= st_applied;
      rcnt_reg <= '0;
      rapplied_reg <= 1'b0; // [R8]
    end else begin
      lst_reg <= lst_next;
      lcnt_reg <= lcnt_next;
      lapplied_reg <= lapplied_next;
      rst_reg <= rst_next;
      rcnt_reg <= rcnt_next;
      rapplied_reg <= rapplied_next;
    end
  end

  // ==========================================================================
  // Read path
  // ==========================================================================
  logic [31:0] prdata_next;
  logic pslverr_next;
  logic pready_next;

  always_comb begin
    prdata_next = '0;
    // Bits 7..5 and 1 are never stored and read back zero.
    if (hit_left) begin
      prdata_next[gain_msb:gain_lsb] = lgain_reg; // [R1] [R6]
      prdata_next[unmute_bit] = lmute_reg;
      prdata_next[applied_bit] = lapplied_reg; // [R7]
    end else if (hit_right) begin
      prdata_next[gain_msb:gain_lsb] = rgain_reg;
      prdata_next[unmute_bit] = rmute_reg;
      prdata_next[applied_bit] = rapplied_reg; // [R8]
    end
    // The headphone register lives outside this bank, so it answers with an error.
    pslverr_next = psel & ~penable & ~(hit_left | hit_right);
    pready_next = psel & ~penable;
  end

  // Read data and error are registered in the setup cycle, so every access
  // completes in its first access cycle with flopped outputs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      prdata <= prdata_next;
      pslverr <= pslverr_next;
      pready <= pready_next;
    end
  end

  // ==========================================================================
  // Driver outputs
  // ==========================================================================
  // Straight from the control flops, so the analog side never sees decode glitches.
  assign left_speaker_driver_gain = lgain_reg;
  assign left_speaker_driver_unmute = lmute_reg;
  assign right_speaker_driver_gain = rgain_reg;
  assign right_speaker_driver_unmute = rmute_reg;

endmodule

// file: verif/spk_drv_properties.sv
// Concurrent checks on the speaker driver control register ports.
`timescale 1ns/10ps
// ==========================================================================
// Checker
// ==========================================================================
module spk_drv_properties
  import spk_drv_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Driver controls
  input wire logic [1:0] left_speaker_driver_gain,
  input wire logic left_speaker_driver_unmute,
  input wire logic [1:0] right_speaker_driver_gain,
  input wire logic right_speaker_driver_unmute
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // A status read three cycles after a write must still see the setting pending.
  wire acc = psel && penable && pready;
  wire wl = acc && pwrite && paddr == left_ctrl_addr;
  wire wr = acc && pwrite && paddr == right_ctrl_addr;
  wire rl = acc && !pwrite && paddr == left_ctrl_addr;
  wire rr = acc && !pwrite && paddr == right_ctrl_addr;
  a_left_gain: assert property (wl |=> left_speaker_driver_gain == $past(pwdata[4:3]))
    else $error("left gain not taken from write");
  a_gain_hold: assert property (!wl |=> $stable(left_speaker_driver_gain))
    else $error("left gain changed without a write");
  a_right_gain: assert property (wr |=> right_speaker_driver_gain == $past(pwdata[4:3]))
    else $error("right gain not taken from write");
  a_left_mute: assert property (wl |=> left_speaker_driver_unmute == $past(pwdata[2]))
    else $error("left mute not taken from write");
  a_right_mute: assert property (wr |=> right_speaker_driver_unmute == $past(pwdata[2]))
    else $error("right mute not taken from write");
  a_rsv_zero: assert property (acc && !pwrite |-> prdata[7:5] == 3'h0 && !prdata[1])
    else $error("reserved bits read nonzero");
  a_left_pend: assert property (wl |=> (!(rl && prdata[0]))[*3])
    else $error("left status set too early");
  a_right_pend: assert property (wr |=> (!(rr && prdata[0]))[*3])
    else $error("right status set too early");
  cover property (wl);
  cover property (rl && prdata[0]);
  cover property (acc && pslverr);
  cover property (rl && !prdata[0]);
endmodule

bind speaker_driver_ctrl_regs spk_drv_properties u_props (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .left_speaker_driver_gain,
  .left_speaker_driver_unmute, .right_speaker_driver_gain, .right_speaker_driver_unmute);

// file: verif/speaker_driver_ctrl_regs_tb_top.sv
// Self-checking bench for the speaker driver control registers.
`timescale 1ns/10ps
// ==========================================================================
// Bench
// ==========================================================================
module speaker_driver_ctrl_regs_tb_top
  import spk_drv_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [1:0] left_speaker_driver_gain, right_speaker_driver_gain;
  logic left_speaker_driver_unmute, right_speaker_driver_unmute;
  int fails = 0, n_tests = 0;
  speaker_driver_ctrl_regs dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .left_speaker_driver_gain, .left_speaker_driver_unmute,
    .right_speaker_driver_gain, .right_speaker_driver_unmute);
  initial forever #10 pclk = ~pclk;
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // One idle edge first, so a release and the next setup never share a time step.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function logic [31:0] outs;
    return {26'h0, left_speaker_driver_gain, left_speaker_driver_unmute,
      right_speaker_driver_gain, right_speaker_driver_unmute};
  endfunction
  task t_reset;
    chk(outs(), 32'h0);
    apb(1'b0, left_ctrl_addr, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h0);
    apb(1'b0, right_ctrl_addr, 32'h0);
    chk(rd, 32'h0);
  endtask
  // Reserved and status bits are written as ones; reserved bits must read back as zero, status zero until settled.
  task t_gains;
    logic [31:0] el, er;
    for (int i = 0; i < 4; i++) begin
      el = {27'h0, i[1:0], i[0], 2'h0};
      er = {27'h0, 2'(3 - i), !i[0], 2'h0};
      apb(1'b1, left_ctrl_addr, 32'hffffffe3 | el);
      apb(1'b0, left_ctrl_addr, 32'h0);
      chk(rd, el);
      apb(1'b1, right_ctrl_addr, 32'hffffffe3 | er);
      apb(1'b0, right_ctrl_addr, 32'h0);
      chk(rd, er);
      chk(outs(), {26'h0, el[4:2], er[4:2]});
      repeat (8) @(posedge pclk);
      apb(1'b0, left_ctrl_addr, 32'h0);
      chk(rd, el | 32'h1);
      apb(1'b0, right_ctrl_addr, 32'h0);
      chk(rd, er | 32'h1);
    end
  endtask
  task t_unmapped;
    apb(1'b1, 12'h0b0, 32'h1c);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 12'h0b0, 32'h0);
    chk(rd, 32'h0);
    chk(outs(), 32'h38);
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_gains();
    t_unmapped();
    wrap_up();
  end
  initial begin
    repeat (5000) @(posedge pclk);
    fails++;
    wrap_up();
  end
endmodule
